// ==== rcp_pkg.sv ====
// Purpose: shared constants and types for the real-time counter block
// Assumes: 25 MHz pclk, APB register access with 32-bit data
// Notes: register offsets are byte addresses, one aligned word each
package rcp_pkg;

	// clock and timing
	localparam int CLK_HZ = 25000000;
	localparam real WDT_BASE_TIMEOUT_S = 0.016; // watchdog period at divide factor 1
	localparam int WDT_BASE_CYCLES = $rtoi(WDT_BASE_TIMEOUT_S * CLK_HZ); // round down
	localparam int QUAD_CLOCKS_PER_INST = 4;
	localparam int ISR_DELAY_INST = 3;
	localparam int WDT_CNT_W = 24;

	// register byte offsets
	localparam logic [7:0] OFS_OPTION = 8'h00;
	localparam logic [7:0] OFS_FILE01 = 8'h04;
	localparam logic [7:0] OFS_COUNTER = 8'h08;
	localparam logic [7:0] OFS_WACC = 8'h0c;
	localparam logic [7:0] OFS_STATUS = 8'h10;
	localparam logic [7:0] OFS_MASK = 8'h14;
	localparam logic [7:0] OFS_WDT_CLEAR = 8'h18;
	localparam logic [7:0] OFS_CTRL = 8'h1c;

	// option register fields
	localparam int OPT_ADDR01_MAP = 7;
	localparam int OPT_IRQ_EN_N = 6;
	localparam int OPT_SRC_SEL = 5;
	localparam int OPT_EDGE_POL = 4;
	localparam int OPT_PSA = 3;
	localparam int OPT_PS_LSB = 0;
	localparam int OPT_PS_W = 3;
	localparam logic [7:0] OPTION_RESET = 8'hff;

	// status and mask fields
	localparam int ST_ROLLOVER = 0;
	localparam int ST_WDT = 1;
	localparam int ST_W = 2;
	localparam logic [1:0] MASK_RESET = 2'h0;

	// control register field
	localparam int CTRL_QUAD = 0;

	// service entry delay sequencer
	typedef enum logic [0:0] {
		ISR_IDLE = 1'b0,
		ISR_WAIT = 1'b1
	} rcp_isr_st_t;

endpackage

// ==== rcp_edge_sync.sv ====
// Purpose: two-stage synchroniser and polarity-selected edge detector
// Assumes: pin is asynchronous to pclk
// Notes: edge pulse lasts one pclk cycle
`timescale 1ns/100ps
module rcp_edge_sync (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic clk_en,
	input wire logic pin,
	input wire logic falling_sel,
	output logic edge_pulse
);
	typedef struct packed {
		logic s1;
		logic s2;
		logic s3;
	} rcp_sync_t;

	rcp_sync_t st_reg;
	rcp_sync_t st_next;

	// shift chain; s1 feeds only s2
	always_comb begin
		st_next = st_reg;
		st_next.s1 = pin;
		st_next.s2 = st_reg.s1;
		st_next.s3 = st_reg.s2;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st_reg <= '0;
		end else if (clk_en) begin
			st_reg <= st_next;
		end
	end

	// edge selection on synchronised samples only
	assign edge_pulse = clk_en & (falling_sel ? (st_reg.s3 & ~st_reg.s2)
		: (~st_reg.s3 & st_reg.s2));
endmodule // rcp_edge_sync

// ==== rcp_prescaler.sv ====
// Purpose: shared power-of-two prescaler
// Assumes: in_tick is a one-cycle strobe on pclk
// Notes: out_tick is combinational, one cycle, on the terminal input tick
`timescale 1ns/100ps
module rcp_prescaler #(
	parameter int WIDTH = 8
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic clk_en,
	input wire logic clear,
	input wire logic in_tick,
	input wire logic [3:0] log2_div,
	output logic out_tick
);
	typedef struct packed {
		logic [WIDTH-1:0] count;
	} rcp_psc_t;

	rcp_psc_t st_reg;
	rcp_psc_t st_next;
	logic [WIDTH:0] span;
	logic [WIDTH-1:0] last;

	// terminal count is 2^log2_div - 1
	assign span = ({{WIDTH{1'b0}}, 1'b1} << log2_div) - {{WIDTH{1'b0}}, 1'b1};
	assign last = span[WIDTH-1:0];
	assign out_tick = clk_en & ~clear & in_tick & (st_reg.count == last);

	// count input ticks, restart on terminal or clear
	always_comb begin
		st_next = st_reg;
		if (clear || out_tick) begin
			st_next.count = '0;
		end else if (in_tick) begin
			st_next.count = st_reg.count + {{(WIDTH-1){1'b0}}, 1'b1};
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st_reg <= '0;
		end else if (clk_en) begin
			st_reg <= st_next;
		end
	end
endmodule // rcp_prescaler

// ==== rcp_rt_counter.sv ====
// Purpose: option register, real-time counter, shared prescaler and watchdog divider
// Assumes: APB slave with one wait state, single pclk domain
// Notes: counter pin and option unlock fuse arrive asynchronously and are synchronised
//
// Our own choices: the APB slave port and the register addresses.
`timescale 1ns/100ps

// Behaviour
// - any reset sets every option register bit to one.
// - file address 01h reaches the accumulator when map select is zero, else the counter.
// - on the small variant the upper two option bits act only when the unlock fuse is zero.
// - the rollover interrupt is enabled when its active-low enable bit is zero.
// - with source select zero the counter advances from instruction cycles.
// - with source select one the counter advances on detected pin transitions.
// - edge polarity one selects falling edges, zero rising edges.
// - prescaler assign zero routes the prescaler to the counter, watchdog undivided.
// - prescaler assign one routes it to the watchdog and the counter runs undivided.
// - counter division is two to the power of the prescale field plus one.
// - watchdog reset comes after two to the power of the prescale field overflows.
// - the watchdog timeout doubles per prescale step from the base period.
// - in quad-clock mode one instruction cycle is four clocks, else one.
// - a taken rollover interrupt enters service after three cycles.
module rcp_rt_counter #(
	parameter bit LARGE_VARIANT = 1'b0,
	parameter int WDT_BASE_CYCLES = rcp_pkg::WDT_BASE_CYCLES,
	parameter int PSC_WIDTH = 8
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic clk_en,
	input wire logic [7:0] paddr,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic counter_pin,
	input wire logic option_unlock_fuse,
	output logic irq,
	output logic isr_entry,
	output logic wdt_reset,
	output logic [7:0] realtime_counter
);
	typedef struct packed {
		logic [7:0] option;
		logic [7:0] counter;
		logic [7:0] wacc;
		logic [rcp_pkg::ST_W-1:0] status;
		logic [rcp_pkg::ST_W-1:0] mask;
		logic quad;
		logic [1:0] iphase;
		logic [rcp_pkg::WDT_CNT_W-1:0] wdt_base;
		rcp_pkg::rcp_isr_st_t isr_st;
		logic [1:0] isr_cnt;
		logic isr_entry;
		logic wdt_reset;
		logic fuse_s1;
		logic fuse_s2;
		logic ack;
		logic [31:0] prdata;
		logic pslverr;
	} rcp_state_t;

	localparam logic [rcp_pkg::WDT_CNT_W-1:0] WDT_LAST =
		rcp_pkg::WDT_CNT_W'(WDT_BASE_CYCLES - 1);
	localparam logic [1:0] QUAD_LAST = 2'(rcp_pkg::QUAD_CLOCKS_PER_INST - 1);
	localparam logic [1:0] ISR_LAST = 2'(rcp_pkg::ISR_DELAY_INST - 1);

	rcp_state_t st_reg;
	rcp_state_t st_next;

	logic [7:0] opt_eff;
	logic map_counter;
	logic irq_en;
	logic src_ext;
	logic prescaler_assign;
	logic [2:0] ps;
	logic inst_tick;
	logic pin_edge;
	logic src_tick;
	logic wdt_ovf;
	logic psc_in;
	logic psc_out;
	logic psc_clear;
	logic [3:0] psc_log2;
	logic count_tick;
	logic bus_write;
	logic wdt_kick;
	logic rollover;
	logic rollover_irq;

	// upper option bits read as one while locked on the small variant
	function automatic logic [7:0] effective_option(input logic [7:0] opt, input logic fuse);
		logic unlocked;
		unlocked = LARGE_VARIANT || !fuse;
		effective_option = unlocked ? opt : {2'b11, opt[5:0]};
	endfunction

	// address match against one register offset
	function automatic logic reg_hit(input logic [7:0] addr, input logic [7:0] ofs);
		reg_hit = (addr[7:2] == ofs[7:2]);
	endfunction

	// decoded option fields
	assign opt_eff = effective_option(st_reg.option, st_reg.fuse_s2);
	assign map_counter = opt_eff[rcp_pkg::OPT_ADDR01_MAP];
	assign irq_en = ~opt_eff[rcp_pkg::OPT_IRQ_EN_N];
	assign src_ext = opt_eff[rcp_pkg::OPT_SRC_SEL];
	assign prescaler_assign = opt_eff[rcp_pkg::OPT_PSA];
	assign ps = opt_eff[rcp_pkg::OPT_PS_LSB +: rcp_pkg::OPT_PS_W];

	// instruction cycle strobe
	assign inst_tick = clk_en & (!st_reg.quad || st_reg.iphase == QUAD_LAST);

	// external pin edges
	rcp_edge_sync u_edge (
		.pclk(pclk),
		.presetn(presetn),
		.clk_en(clk_en),
		.pin(counter_pin),
		.falling_sel(opt_eff[rcp_pkg::OPT_EDGE_POL]),
		.edge_pulse(pin_edge)
	);

	// count source and prescaler routing
	assign src_tick = src_ext ? pin_edge : inst_tick;
	assign wdt_ovf = clk_en & (st_reg.wdt_base == WDT_LAST);
	assign psc_in = prescaler_assign ? wdt_ovf : src_tick;
	assign psc_log2 = prescaler_assign ? {1'b0, ps} : ({1'b0, ps} + 4'h1);
	assign count_tick = prescaler_assign ? src_tick : psc_out;

	// bus strobes
	assign bus_write = psel & penable & pwrite & st_reg.ack;
	assign wdt_kick = bus_write & reg_hit(paddr, rcp_pkg::OFS_WDT_CLEAR);
	assign psc_clear = (bus_write & reg_hit(paddr, rcp_pkg::OFS_OPTION)
		& (pwdata[rcp_pkg::OPT_PSA] != st_reg.option[rcp_pkg::OPT_PSA]))
		| (prescaler_assign & wdt_kick);

	rcp_prescaler #(
		.WIDTH(PSC_WIDTH)
	) u_psc (
		.pclk(pclk),
		.presetn(presetn),
		.clk_en(clk_en),
		.clear(psc_clear),
		.in_tick(psc_in),
		.log2_div(psc_log2),
		.out_tick(psc_out)
	);

	// wrap detection
	assign rollover = count_tick & (st_reg.counter == 8'hff);
	assign rollover_irq = rollover & irq_en & st_reg.mask[rcp_pkg::ST_ROLLOVER];

	// next-state logic
	always_comb begin
		logic [rcp_pkg::ST_W-1:0] events;
		logic [rcp_pkg::ST_W-1:0] w1c;
		logic wr_counter;
		events = '0;
		w1c = '0;
		wr_counter = 1'b0;
		st_next = st_reg;
		st_next.isr_entry = 1'b0;
		st_next.wdt_reset = 1'b0;

		// fuse level synchroniser
		st_next.fuse_s1 = option_unlock_fuse;
		st_next.fuse_s2 = st_reg.fuse_s1;

		// instruction phase in quad mode
		if (st_reg.quad) begin
			st_next.iphase = st_reg.iphase + 2'h1;
		end else begin
			st_next.iphase = 2'h0;
		end

		// watchdog base period
		if (wdt_kick || wdt_ovf) begin
			st_next.wdt_base = '0;
		end else begin
			st_next.wdt_base = st_reg.wdt_base + rcp_pkg::WDT_CNT_W'(1);
		end
		if (!wdt_kick && (prescaler_assign ? psc_out : wdt_ovf)) begin
			st_next.wdt_reset = 1'b1;
			events[rcp_pkg::ST_WDT] = 1'b1;
		end

		// counter advance
		if (count_tick) begin
			st_next.counter = st_reg.counter + 8'h01;
		end
		if (rollover) begin
			events[rcp_pkg::ST_ROLLOVER] = 1'b1;
		end

		// bus access: first access cycle loads read data, second completes
		st_next.ack = psel & penable & ~st_reg.ack;
		if (psel && penable && !st_reg.ack) begin
			st_next.prdata = 32'h0;
			st_next.pslverr = 1'b0;
			if (reg_hit(paddr, rcp_pkg::OFS_OPTION)) begin
				st_next.prdata = {24'h0, opt_eff};
			end else if (reg_hit(paddr, rcp_pkg::OFS_FILE01)) begin
				st_next.prdata = {24'h0, map_counter ? st_reg.counter : st_reg.wacc};
			end else if (reg_hit(paddr, rcp_pkg::OFS_COUNTER)) begin
				st_next.prdata = {24'h0, st_reg.counter};
			end else if (reg_hit(paddr, rcp_pkg::OFS_WACC)) begin
				st_next.prdata = {24'h0, st_reg.wacc};
			end else if (reg_hit(paddr, rcp_pkg::OFS_STATUS)) begin
				st_next.prdata = {30'h0, st_reg.status};
			end else if (reg_hit(paddr, rcp_pkg::OFS_MASK)) begin
				st_next.prdata = {30'h0, st_reg.mask};
			end else if (reg_hit(paddr, rcp_pkg::OFS_CTRL)) begin
				st_next.prdata = {31'h0, st_reg.quad};
			end else if (!reg_hit(paddr, rcp_pkg::OFS_WDT_CLEAR)) begin
				st_next.pslverr = 1'b1;
			end
		end

		// register writes at the completing edge
		if (bus_write) begin
			if (reg_hit(paddr, rcp_pkg::OFS_OPTION)) begin
				st_next.option = pwdata[7:0];
			end else if (reg_hit(paddr, rcp_pkg::OFS_FILE01)) begin
				if (map_counter) begin
					wr_counter = 1'b1;
				end else begin
					st_next.wacc = pwdata[7:0];
				end
			end else if (reg_hit(paddr, rcp_pkg::OFS_COUNTER)) begin
				wr_counter = 1'b1;
			end else if (reg_hit(paddr, rcp_pkg::OFS_WACC)) begin
				st_next.wacc = pwdata[7:0];
			end else if (reg_hit(paddr, rcp_pkg::OFS_STATUS)) begin
				w1c = pwdata[rcp_pkg::ST_W-1:0];
			end else if (reg_hit(paddr, rcp_pkg::OFS_MASK)) begin
				st_next.mask = pwdata[rcp_pkg::ST_W-1:0];
			end else if (reg_hit(paddr, rcp_pkg::OFS_CTRL)) begin
				st_next.quad = pwdata[rcp_pkg::CTRL_QUAD];
				st_next.iphase = 2'h0;
			end
		end
		if (wr_counter) begin
			st_next.counter = pwdata[7:0]; // software write beats the advance
		end

		// sticky status, a new event beats a clear
		st_next.status = (st_reg.status & ~w1c) | events;

		// service entry three instruction cycles after the taken interrupt
		case (st_reg.isr_st)
			rcp_pkg::ISR_IDLE: begin
				if (rollover_irq) begin
					st_next.isr_st = rcp_pkg::ISR_WAIT;
					st_next.isr_cnt = 2'h0;
				end
			end
			rcp_pkg::ISR_WAIT: begin
				if (inst_tick) begin
					if (st_reg.isr_cnt == ISR_LAST) begin
						st_next.isr_entry = 1'b1;
						st_next.isr_st = rcp_pkg::ISR_IDLE;
					end else begin
						st_next.isr_cnt = st_reg.isr_cnt + 2'h1;
					end
				end
			end
			default: begin
				st_next.isr_st = rcp_pkg::ISR_IDLE;
			end
		endcase
	end

	// state register, frozen while clk_en is low
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st_reg <= '0;
			st_reg.option <= rcp_pkg::OPTION_RESET;
			st_reg.mask <= rcp_pkg::MASK_RESET;
			st_reg.isr_st <= rcp_pkg::ISR_IDLE;
		end else if (clk_en) begin
			st_reg <= st_next;
		end
	end

	// outputs
	assign prdata = st_reg.prdata;
	assign pready = st_reg.ack;
	assign pslverr = st_reg.ack & st_reg.pslverr;
	assign irq = (st_reg.status[rcp_pkg::ST_ROLLOVER] & st_reg.mask[rcp_pkg::ST_ROLLOVER]
		& irq_en)
		| (st_reg.status[rcp_pkg::ST_WDT] & st_reg.mask[rcp_pkg::ST_WDT]);
	assign isr_entry = st_reg.isr_entry;
	assign wdt_reset = st_reg.wdt_reset;
	assign realtime_counter = st_reg.counter;
endmodule // rcp_rt_counter

// ==== rcp_pin_source.sv ====
// Purpose: external event source driving the counter input pin
// Assumes: pin idles low and is a driven level, no pull
// Notes: burst levels last about 100 ns, unrelated in phase to pclk
`timescale 1ns/100ps
module rcp_pin_source (
	output logic counter_pin
);
	// idle level from time zero
	initial counter_pin = 1'b0;

	// n full pulses, then time for the far side to see them
	task automatic burst(input int n);
		repeat (n) begin
			#103 counter_pin = 1'b1;
			#97 counter_pin = 1'b0;
		end
		#250;
	endtask

	// one slow level change
	task automatic drive(input logic v);
		counter_pin = v;
		#250;
	endtask
endmodule // rcp_pin_source

// ==== rcp_rt_counter_monitor.sv ====
// Purpose: port checks for the real-time counter block
// Assumes: one pclk domain, asynchronous active-low reset
// Notes: bound to every instance of the block
`timescale 1ns/100ps
module rcp_rt_counter_monitor #(
	parameter bit LARGE_VARIANT = 1'b0,
	parameter int WDT_BASE_CYCLES = rcp_pkg::WDT_BASE_CYCLES,
	parameter int PSC_WIDTH = 8
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic clk_en,
	input wire logic [7:0] paddr,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic counter_pin,
	input wire logic option_unlock_fuse,
	input wire logic irq,
	input wire logic isr_entry,
	input wire logic wdt_reset,
	input wire logic [7:0] realtime_counter
);
	default clocking @(posedge pclk);
	endclocking
	default disable iff (!presetn);

	// a write that completes at this edge
	logic wr_done;
	assign wr_done = psel && penable && pwrite && pready;

	// checked properties
	property p_rst_vals;
		$rose(presetn) |-> realtime_counter == 8'h00 && !irq && !pready;
	endproperty
	a_rst_vals: assert property (p_rst_vals) else $error("outputs not idle after reset");
	property p_cnt_step;
		$changed(realtime_counter) && !$past(wr_done) |-> realtime_counter == $past(realtime_counter) + 8'h01;
	endproperty
	a_cnt_step: assert property (p_cnt_step) else $error("counter moved by other than one");
	property p_irq_fall;
		$fell(irq) |-> $past(wr_done) || $past(wr_done, 2);
	endproperty
	a_irq_fall: assert property (p_irq_fall) else $error("irq dropped without a write");
	property p_isr_pulse;
		isr_entry |=> !isr_entry;
	endproperty
	a_isr_pulse: assert property (p_isr_pulse) else $error("service entry not one cycle");
	property p_wdt_pulse;
		wdt_reset |=> !wdt_reset;
	endproperty
	a_wdt_pulse: assert property (p_wdt_pulse) else $error("watchdog reset not one cycle");
	property p_ans;
		psel && $rose(penable) && clk_en |=> pready;
	endproperty
	a_ans: assert property (p_ans) else $error("bus answer late");
	property p_rdy_once;
		pready |=> !pready;
	endproperty
	a_rdy_once: assert property (p_rdy_once) else $error("pready held too long");
	property p_err_ack;
		pslverr |-> pready && psel && penable;
	endproperty
	a_err_ack: assert property (p_err_ack) else $error("pslverr outside a transfer");

	// main scenarios reached
	c_isr: cover property (isr_entry);
	c_wdt: cover property (wdt_reset);
	c_wrap: cover property (realtime_counter == 8'h00 && $past(realtime_counter) == 8'hff);
endmodule // rcp_rt_counter_monitor

bind rcp_rt_counter rcp_rt_counter_monitor #(
	.LARGE_VARIANT(LARGE_VARIANT), .WDT_BASE_CYCLES(WDT_BASE_CYCLES), .PSC_WIDTH(PSC_WIDTH)
) rcp_rt_counter_monitor_inst (
	.pclk(pclk), .presetn(presetn), .clk_en(clk_en), .paddr(paddr), .psel(psel),
	.penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
	.pslverr(pslverr), .counter_pin(counter_pin), .option_unlock_fuse(option_unlock_fuse),
	.irq(irq), .isr_entry(isr_entry), .wdt_reset(wdt_reset), .realtime_counter(realtime_counter)
);

// ==== tb_top.sv ====
// Purpose: self-checking bench for the real-time counter block
// Assumes: watchdog base period shortened to 20 clocks
// Notes: pin events come from the partner model
`timescale 1ns/100ps
module tb_top;
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic clk_en = 1'b1;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic option_unlock_fuse = 1'b1;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata, rd;
	logic pready, pslverr, irq, isr_entry, wdt_reset, counter_pin, err;
	logic [7:0] realtime_counter, c0;
	int failures = 0, tests_run = 0, isr_seen = 0, wdt_seen = 0, i0, n0;
	logic [7:0] wd_opt [4] = '{8'hb0, 8'hb8, 8'hb9, 8'hba};
	int wd_exp [4] = '{10, 10, 5, 2};
	int ps_tab [4] = '{0, 1, 2, 7};

	// 40 ns clock
	always #20 pclk = ~pclk;

	rcp_rt_counter #(.WDT_BASE_CYCLES(20)) rcp_rt_counter_inst (
		.pclk(pclk), .presetn(presetn), .clk_en(clk_en), .paddr(paddr), .psel(psel),
		.penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .counter_pin(counter_pin), .option_unlock_fuse(option_unlock_fuse),
		.irq(irq), .isr_entry(isr_entry), .wdt_reset(wdt_reset), .realtime_counter(realtime_counter)
	);
	rcp_pin_source rcp_pin_source_inst (.counter_pin(counter_pin));

	// tally of output pulses
	always @(posedge pclk) begin
		if (isr_entry === 1'b1)
			isr_seen <= isr_seen + 1;
		if (wdt_reset === 1'b1)
			wdt_seen <= wdt_seen + 1;
	end

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp) begin
			failures++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	// one bus transfer, held until pready is sampled high
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1 && ++n < 50);
		if (n >= 50)
			chk(32'h0, 32'h1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask

	task automatic rdc(input logic [7:0] a, input logic [31:0] e);
		apb(1'b0, a, 32'h0);
		chk(rd, e);
	endtask

	// counter advance between two back-to-back reads
	task automatic rate(input logic [7:0] e);
		apb(1'b0, 8'h08, 32'h0);
		c0 = rd[7:0];
		apb(1'b0, 8'h08, 32'h0);
		chk({24'h0, rd[7:0] - c0}, {24'h0, e});
	endtask

	task automatic irq_is(input logic v);
		repeat (3) @(posedge pclk);
		chk({31'h0, irq}, {31'h0, v});
	endtask

	task automatic end_sim;
		$display("Checks %0d, mismatches %0d", tests_run, failures);
		if (failures == 0 && tests_run > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask

	// main sequence
	initial begin
		repeat (5) @(posedge pclk);
		presetn <= 1'b1;
		rdc(8'h00, 32'hff);
		rdc(8'h14, 32'h0);
		rdc(8'h08, 32'h0);
		apb(1'b0, 8'h20, 32'h0);
		chk({31'h0, err}, 32'h1);
		wr(8'h00, 32'h28);
		rdc(8'h00, 32'he8);
		option_unlock_fuse <= 1'b0;
		wr(8'h00, 32'h28);
		rdc(8'h00, 32'h28);
		wr(8'h0c, 32'h5a);
		rdc(8'h04, 32'h5a);
		wr(8'h00, 32'ha8);
		wr(8'h08, 32'h33);
		rdc(8'h04, 32'h33);
		chk({24'h0, realtime_counter}, 32'h33);
		rdc(8'h0c, 32'h5a);
		$display("Test option and map done");
		wr(8'h08, 32'h0);
		rcp_pin_source_inst.burst(5);
		rdc(8'h08, 32'h5);
		wr(8'h00, 32'hb8);
		wr(8'h08, 32'h0);
		rcp_pin_source_inst.drive(1'b1);
		rdc(8'h08, 32'h0);
		rcp_pin_source_inst.drive(1'b0);
		rdc(8'h08, 32'h1);
		foreach (ps_tab[i]) begin
			wr(8'h00, 32'ha8);
			wr(8'h00, 32'ha0 | ps_tab[i]);
			wr(8'h08, 32'h0);
			rcp_pin_source_inst.burst((2 << ps_tab[i]) - 1);
			rdc(8'h08, 32'h0);
			rcp_pin_source_inst.burst(1);
			rdc(8'h08, 32'h1);
		end
		wr(8'h00, 32'h88);
		rate(8'h4);
		// freeze with clk_en low right after a watchdog kick, so no pulse is held
		wr(8'h18, 32'h0);
		apb(1'b0, 8'h08, 32'h0);
		c0 = rd[7:0];
		clk_en <= 1'b0;
		repeat (6) @(posedge pclk);
		clk_en <= 1'b1;
		apb(1'b0, 8'h08, 32'h0);
		chk({24'h0, rd[7:0] - c0}, 32'h4);
		wr(8'h1c, 32'h1);
		rate(8'h1);
		wr(8'h1c, 32'h0);
		wr(8'h00, 32'h80);
		rate(8'h2);
		$display("Test counting done");
		wr(8'h00, 32'ha8);
		wr(8'h10, 32'h3);
		wr(8'h14, 32'h1);
		wr(8'h08, 32'hff);
		i0 = isr_seen;
		rcp_pin_source_inst.burst(1);
		apb(1'b0, 8'h10, 32'h0);
		chk({31'h0, rd[0]}, 32'h1);
		irq_is(1'b1);
		chk(isr_seen - i0, 32'h1);
		wr(8'h14, 32'h0);
		irq_is(1'b0);
		wr(8'h14, 32'h1);
		irq_is(1'b1);
		wr(8'h10, 32'h1);
		irq_is(1'b0);
		wr(8'h00, 32'he8);
		wr(8'h08, 32'hff);
		rcp_pin_source_inst.burst(1);
		apb(1'b0, 8'h10, 32'h0);
		chk({31'h0, rd[0]}, 32'h1);
		irq_is(1'b0);
		chk(isr_seen - i0, 32'h1);
		$display("Test interrupt done");
		foreach (wd_opt[i]) begin
			wr(8'h00, {24'h0, wd_opt[i]});
			wr(8'h18, 32'h0);
			@(posedge pclk);
			n0 = wdt_seen;
			repeat (209) @(posedge pclk);
			chk(wdt_seen - n0, wd_exp[i]);
		end
		$display("Test watchdog done");
		presetn <= 1'b0;
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		rdc(8'h00, 32'hff);
		rdc(8'h14, 32'h0);
		$display("Test second reset done");
		end_sim();
	end

	// hang guard
	initial begin
		#800000;
		failures++;
		end_sim();
	end
endmodule // tb_top
